// >>> core/dect_pkg.sv
// package for the dual event counter/timer: register map, encodings, states
// assumes one 20 MHz clock and an Avalon-MM slave with waitrequest
package dect_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam int TICK_W = 5;
  localparam int CNT_W = 32;
  localparam int SRC_W = 5;
  localparam int ADDR_W = 6;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_SELECT = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT_SRC = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG_SRC = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RESET_SRC = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_DELAY = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DURATION = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_VALUE = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_AT_RESET = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h28;

  // source register layout: select in [4:0], qualifier in [10:8]
  localparam int SEL_LSB = 0;
  localparam int QUAL_LSB = 8;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

  typedef enum logic [SRC_W-1:0] {
    SRC_OFF = 5'h00, SRC_TICK = 5'h01,
    SRC_LINE0 = 5'h02, SRC_LINE1 = 5'h03, SRC_LINE2 = 5'h04, SRC_LINE3 = 5'h05,
    SRC_UOUT0 = 5'h06, SRC_UOUT1 = 5'h07, SRC_UOUT2 = 5'h08, SRC_UOUT3 = 5'h09,
    SRC_C0_START = 5'h0a, SRC_C1_START = 5'h0b, SRC_C0_END = 5'h0c, SRC_C1_END = 5'h0d,
    SRC_LOGIC0 = 5'h0e, SRC_LOGIC1 = 5'h0f,
    SRC_EXP_START = 5'h10, SRC_EXP_END = 5'h11, SRC_FRAME_WAIT = 5'h12
  } dect_src_t;

  typedef enum logic [2:0] {
    QUAL_LEVEL_LOW = 3'h0, QUAL_LEVEL_HIGH = 3'h1, QUAL_FALLING = 3'h2,
    QUAL_RISING = 3'h3, QUAL_ANY_EDGE = 3'h4
  } dect_qual_t;

  typedef struct packed {
    dect_src_t sel;
    dect_qual_t qual;
  } dect_srccfg_t;

  localparam dect_srccfg_t SRCCFG_RESET = '{sel: SRC_OFF, qual: QUAL_RISING};

  // gray along idle -> wait -> delay -> duration -> done
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT_TRIG = 3'b001, ST_DELAY = 3'b011,
    ST_DURATION = 3'b010, ST_DONE = 3'b110
  } dect_state_t;

  typedef struct packed {
    logic [3:0] lines;
    logic [3:0] user_out;
    logic [1:0] logic_out;
    logic exp_start;
    logic exp_end;
    logic frame_wait;
  } dect_sig_t;

  // irq bits: [0] c0 start, [1] c0 end, [2] c1 start, [3] c1 end
  localparam int IRQ_W = 4;
endpackage

// >>> core/dect_counter.sv
// one counter channel: source qualifiers, state machine, count and capture
// assumes all source levels are already synchronous to clk
`timescale 1ns/100ps
module dect_counter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [18:0] src_vec,
  input wire dect_pkg::dect_srccfg_t count_cfg,
  input wire dect_pkg::dect_srccfg_t trig_cfg,
  input wire dect_pkg::dect_srccfg_t reset_cfg,
  input wire logic [dect_pkg::CNT_W-1:0] start_event_delay_count,
  input wire logic [dect_pkg::CNT_W-1:0] end_event_duration_count,
  input wire logic arm,
  output logic [dect_pkg::CNT_W-1:0] present_count,
  output logic [dect_pkg::CNT_W-1:0] count_captured_on_reset,
  output dect_pkg::dect_state_t counter_state_readback,
  output logic start_event,
  output logic end_event
);
  import dect_pkg::*;

  logic [18:0] prev_reg;
  logic [CNT_W-1:0] cnt_reg, cnt_next, cap_reg, cap_next;
  dect_state_t st_reg, st_next;
  logic start_reg, start_next, end_reg, end_next;
  logic cnt_hit, trig_hit, rst_hit;

  function automatic logic qualify(input dect_srccfg_t cfg, input logic [18:0] now,
                                   input logic [18:0] was);
    logic c;
    logic p;
    c = now[cfg.sel];
    p = was[cfg.sel];
    if (cfg.sel == SRC_OFF) begin
      return 1'b0;
    end
    // the tick is a one-cycle pulse: counted as is
    if (cfg.sel == SRC_TICK) begin
      return c;
    end
    case (cfg.qual)
      QUAL_LEVEL_LOW: return !c;
      QUAL_LEVEL_HIGH: return c;
      QUAL_FALLING: return p && !c;
      QUAL_RISING: return !p && c;
      QUAL_ANY_EDGE: return p != c;
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    cnt_hit = qualify(count_cfg, src_vec, prev_reg);
    trig_hit = qualify(trig_cfg, src_vec, prev_reg);
    rst_hit = qualify(reset_cfg, src_vec, prev_reg);
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    cap_next = cap_reg;
    start_next = 1'b0;
    end_next = 1'b0;
    if (rst_hit) begin
      // stop and clear, keeping the old count readable
      cap_next = cnt_reg;
      cnt_next = '0;
      st_next = ST_IDLE;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (arm) begin
            st_next = (trig_cfg.sel == SRC_OFF) ? ST_DELAY : ST_WAIT_TRIG;
            cnt_next = '0;
          end
        end
        ST_WAIT_TRIG: begin
          if (trig_hit) begin
            st_next = ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (cnt_reg >= start_event_delay_count) begin
            start_next = 1'b1;
            st_next = ST_DURATION;
            cnt_next = '0;
          end else if (cnt_hit) begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        ST_DURATION: begin
          if (cnt_reg >= end_event_duration_count) begin
            end_next = 1'b1;
            st_next = ST_DONE;
          end else if (cnt_hit) begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        ST_DONE: begin
          if (arm) begin
            st_next = ST_IDLE;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= '0;
      cnt_reg <= '0;
      cap_reg <= '0;
      st_reg <= ST_IDLE;
      start_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      prev_reg <= src_vec;
      cnt_reg <= cnt_next;
      cap_reg <= cap_next;
      st_reg <= st_next;
      start_reg <= start_next;
      end_reg <= end_next;
    end
  end

  assign present_count = cnt_reg;
  assign count_captured_on_reset = cap_reg;
  assign counter_state_readback = st_reg;
  assign start_event = start_reg;
  assign end_event = end_reg;
endmodule

// >>> core/dect_top.sv
// dual event counter/timer with Avalon-MM register slave and interrupt
// assumes external lines are asynchronous; other sources come from clk logic
//
// Functional notes
// - two independent counters; selector 0 or 1 picks the addressed one.
// - each counter counts a selectable source from the shared signal set.
// - count source qualified by level low/high, falling, rising or any edge; the tick is counted as is.
// - start event fires once counted occurrences equal the delay value.
// - end event fires once counted occurrences equal the duration value.
// - trigger source and reset source are exclusive; selecting one disables other.
// - counting begins when the selected start trigger fires.
// - start trigger qualified by the same five activation modes.
// - selected reset source stops and clears the counter.
// - reset source qualified by the same five activation modes.
// - present count and status of each counter are readable.
// - count before each reset is captured and held until next reset.
`timescale 1ns/100ps
module dect_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [dect_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dect_pkg::dect_sig_t ext_sig,
  output logic [1:0] start_event,
  output logic [1:0] end_event,
  output logic irq
);
  import dect_pkg::*;

  logic [3:0] line_s1_reg, line_s2_reg;
  logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;
  logic sel_reg, sel_next;
  dect_srccfg_t cnt_cfg_reg [2], cnt_cfg_next [2];
  dect_srccfg_t trg_cfg_reg [2], trg_cfg_next [2];
  dect_srccfg_t rst_cfg_reg [2], rst_cfg_next [2];
  logic [CNT_W-1:0] dly_reg [2], dly_next [2];
  logic [CNT_W-1:0] dur_reg [2], dur_next [2];
  logic [1:0] arm_reg, arm_next;
  logic [IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic [18:0] src_vec;
  logic [CNT_W-1:0] val_w [2];
  logic [CNT_W-1:0] cap_w [2];
  dect_state_t st_w [2];
  logic [1:0] st_ev, en_ev;
  logic wr_go, rd_go;
  dect_srccfg_t wcfg;

  // pins cross into clk through two flops; only the second is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_s1_reg <= '0;
      line_s2_reg <= '0;
    end else begin
      line_s1_reg <= ext_sig.lines;
      line_s2_reg <= line_s1_reg;
    end
  end

  // one-cycle microsecond pulse
  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // index matches dect_src_t encoding; counter events feed back a cycle late
  assign src_vec = {ext_sig.frame_wait, ext_sig.exp_end, ext_sig.exp_start,
                    ext_sig.logic_out, en_ev[1], en_ev[0], st_ev[1], st_ev[0],
                    ext_sig.user_out, line_s2_reg, tick_reg, 1'b0};

  // single-cycle answer: waitrequest high in the first cycle of a request
  // writes land at the edge that ends the transfer, never inside the wait
  assign wr_go = avs_write && ack_reg;
  assign rd_go = avs_read && ack_reg == 1'b0;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wcfg = '{sel: dect_src_t'(avs_writedata[SEL_LSB +: SRC_W]),
                  qual: dect_qual_t'(avs_writedata[QUAL_LSB +: 3])};

  always_comb begin
    sel_next = sel_reg;
    cnt_cfg_next = cnt_cfg_reg;
    trg_cfg_next = trg_cfg_reg;
    rst_cfg_next = rst_cfg_reg;
    dly_next = dly_reg;
    dur_next = dur_reg;
    arm_next = '0;
    imask_next = imask_reg;
    rdata_next = rdata_reg;
    ack_next = (avs_read || avs_write) && !ack_reg;
    // events set, software ones clear; a new event beats the clear
    ist_next = ist_reg;
    if (wr_go && avs_address == OFS_IRQ_STAT && avs_byteenable[0]) begin
      ist_next = ist_reg & ~avs_writedata[IRQ_W-1:0];
    end
    ist_next = ist_next | {en_ev[1], st_ev[1], en_ev[0], st_ev[0]};
    if (wr_go && avs_byteenable == 4'hf) begin
      case (avs_address)
        OFS_SELECT: sel_next = avs_writedata[0];
        OFS_COUNT_SRC: cnt_cfg_next[sel_reg] = wcfg;
        OFS_TRIG_SRC: begin
          trg_cfg_next[sel_reg] = wcfg;
          if (wcfg.sel != SRC_OFF) begin
            rst_cfg_next[sel_reg].sel = SRC_OFF;
          end
          arm_next[sel_reg] = 1'b1;
        end
        OFS_RESET_SRC: begin
          rst_cfg_next[sel_reg] = wcfg;
          if (wcfg.sel != SRC_OFF) begin
            trg_cfg_next[sel_reg].sel = SRC_OFF;
          end
        end
        OFS_DELAY: dly_next[sel_reg] = avs_writedata;
        OFS_DURATION: begin
          dur_next[sel_reg] = avs_writedata;
          arm_next[sel_reg] = 1'b1;
        end
        OFS_IRQ_MASK: imask_next = avs_writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (rd_go) begin
      case (avs_address)
        OFS_SELECT: rdata_next = {31'h0000_0000, sel_reg};
        OFS_COUNT_SRC: rdata_next = {21'h00_0000, cnt_cfg_reg[sel_reg].qual, 3'h0,
                                     cnt_cfg_reg[sel_reg].sel};
        OFS_TRIG_SRC: rdata_next = {21'h00_0000, trg_cfg_reg[sel_reg].qual, 3'h0,
                                    trg_cfg_reg[sel_reg].sel};
        OFS_RESET_SRC: rdata_next = {21'h00_0000, rst_cfg_reg[sel_reg].qual, 3'h0,
                                     rst_cfg_reg[sel_reg].sel};
        OFS_DELAY: rdata_next = dly_reg[sel_reg];
        OFS_DURATION: rdata_next = dur_reg[sel_reg];
        OFS_VALUE: rdata_next = val_w[sel_reg];
        OFS_STATUS: rdata_next = {29'h0000_0000, st_w[sel_reg]};
        OFS_AT_RESET: rdata_next = cap_w[sel_reg];
        OFS_IRQ_STAT: rdata_next = {28'h000_0000, ist_reg};
        OFS_IRQ_MASK: rdata_next = {28'h000_0000, imask_reg};
        default: rdata_next = BAD_ADDR_DATA;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_reg <= 1'b0;
      cnt_cfg_reg <= '{SRCCFG_RESET, SRCCFG_RESET};
      trg_cfg_reg <= '{SRCCFG_RESET, SRCCFG_RESET};
      rst_cfg_reg <= '{SRCCFG_RESET, SRCCFG_RESET};
      dly_reg <= '{32'h0000_0000, 32'h0000_0000};
      dur_reg <= '{32'h0000_0000, 32'h0000_0000};
      arm_reg <= '0;
      ist_reg <= '0;
      imask_reg <= '0;
      rdata_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      cnt_cfg_reg <= cnt_cfg_next;
      trg_cfg_reg <= trg_cfg_next;
      rst_cfg_reg <= rst_cfg_next;
      dly_reg <= dly_next;
      dur_reg <= dur_next;
      arm_reg <= arm_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign irq = |(ist_reg & imask_reg);
  assign start_event = st_ev;
  assign end_event = en_ev;

  // two identical channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    dect_counter u_ch (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_vec(src_vec),
      .count_cfg(cnt_cfg_reg[i]),
      .trig_cfg(trg_cfg_reg[i]),
      .reset_cfg(rst_cfg_reg[i]),
      .start_event_delay_count(dly_reg[i]),
      .end_event_duration_count(dur_reg[i]),
      .arm(arm_reg[i]),
      .present_count(val_w[i]),
      .count_captured_on_reset(cap_w[i]),
      .counter_state_readback(st_w[i]),
      .start_event(st_ev[i]),
      .end_event(en_ev[i])
    );
  end
endmodule

// >>> bench/dect_sva.sv
// checker for dect_top: bus handshake, event pulses and interrupt timing
// assumes it is bound to dect_top and sees only its ports
`timescale 1ns/100ps
module dect_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [dect_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] start_event,
  input wire logic [1:0] end_event,
  input wire logic irq
);
  import dect_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic ev;
  assign req = avs_read | avs_write;
  assign ev = |{start_event, end_event};
  property p_first_wait;
    $rose(req) |-> avs_waitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("no wait in first cycle");
  property p_one_wait;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
  property p_idle_wait;
    !req |-> !avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("wait without request");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 6'h2c |-> avs_readdata == BAD_ADDR_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_start_pulse;
    (start_event & $past(start_event)) == 2'h0;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start event too long");
  property p_end_pulse;
    (end_event & $past(end_event)) == 2'h0;
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("end event too long");
  property p_irq_rise;
    $rose(irq) |-> ev || $past(ev) || $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule
bind dect_top dect_sva dect_sva_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .start_event(start_event), .end_event(end_event),
  .irq(irq));

// >>> bench/testbench.sv
// self-checking bench for dect_top: register access, counting, reset capture, irq
// assumes one 20 MHz clock and the register map of dect_pkg
`timescale 1ns/100ps
module testbench;
  import dect_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic [31:0] rdata;
  logic avs_waitrequest;
  logic irq;
  logic [1:0] start_event;
  logic [1:0] end_event;
  dect_sig_t ext_sig = '0;
  int n_errors = 0;
  int check_count = 0;
  int n_start = 0;
  int n_end = 0;
  always #25 clk = ~clk;
  dect_top dect_top_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_sig(ext_sig), .start_event(start_event),
    .end_event(end_event), .irq(irq));
  always @(posedge clk) begin
    if (start_event[0] === 1'b1) n_start++;
    if (end_event[0] === 1'b1) n_end++;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge; data taken there
  task automatic bus(input logic is_rd, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= is_rd;
    avs_write <= ~is_rd;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    rdata = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      chk(32'h0000_0001, 32'h0000_0000);
      test_done();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0000_0000);
    chk(rdata, exp);
  endtask
  // high for n clocks on one bit of ext_sig, then low
  task automatic pl(input int b, input int n);
    @(posedge clk);
    ext_sig[b] <= 1'b1;
    repeat (n) @(posedge clk);
    ext_sig[b] <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(OFS_STATUS, ST_IDLE);
    rdc(OFS_VALUE, 32'h0000_0000);
    rdc(6'h2c, BAD_ADDR_DATA);
    // user output 0, rising edge
    wr(OFS_COUNT_SRC, 32'h0000_0306);
    wr(OFS_DELAY, 32'h0000_0003);
    wr(OFS_DURATION, 32'h0000_0002);
    rdc(OFS_STATUS, ST_DELAY);
    repeat (2) pl(5, 1);
    rdc(OFS_VALUE, 32'h0000_0002);
    chk(n_start, 32'h0000_0000);
    pl(5, 1);
    rdc(OFS_STATUS, ST_DURATION);
    chk(n_start, 32'h0000_0001);
    repeat (2) pl(5, 1);
    rdc(OFS_STATUS, ST_DONE);
    chk(n_end, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    // the write lands on the edge the task returns at; look one edge later
    @(posedge clk);
    chk(irq, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0002);
    @(posedge clk);
    chk(irq, 32'h0000_0000);
    rdc(OFS_IRQ_STAT, 32'h0000_0001);
    // logic block 0, level high: one count per clock held
    wr(OFS_COUNT_SRC, 32'h0000_010e);
    wr(OFS_DELAY, 32'h0000_0064);
    repeat (2) wr(OFS_DURATION, 32'h0000_0064);
    pl(3, 7);
    rdc(OFS_VALUE, 32'h0000_0007);
    wr(OFS_RESET_SRC, 32'h0000_0311);
    pl(1, 1);
    rdc(OFS_AT_RESET, 32'h0000_0007);
    rdc(OFS_VALUE, 32'h0000_0000);
    rdc(OFS_STATUS, ST_IDLE);
    wr(OFS_TRIG_SRC, 32'h0000_0312);
    bus(1'b1, OFS_RESET_SRC, 32'h0000_0000);
    chk(rdata[4:0], SRC_OFF);
    rdc(OFS_STATUS, ST_WAIT_TRIG);
    pl(0, 1);
    rdc(OFS_STATUS, ST_DELAY);
    // reset source was disabled, so this pulse must do nothing
    pl(1, 1);
    rdc(OFS_STATUS, ST_DELAY);
    rdc(OFS_AT_RESET, 32'h0000_0007);
    wr(OFS_SELECT, 32'h0000_0001);
    rdc(OFS_STATUS, ST_IDLE);
    rdc(OFS_VALUE, 32'h0000_0000);
    wr(OFS_COUNT_SRC, 32'h0000_0401);
    wr(OFS_DELAY, 32'h0000_0064);
    wr(OFS_DURATION, 32'h0000_0064);
    repeat (200) @(posedge clk);
    bus(1'b1, OFS_VALUE, 32'h0000_0000);
    // tick phase is unknown, so allow one count either way
    chk(rdata >= 32'h0000_0009 && rdata <= 32'h0000_000b, 32'h0000_0001);
    wr(OFS_SELECT, 32'h0000_0000);
    rdc(OFS_STATUS, ST_DELAY);
    test_done();
  end
endmodule
